// File: aab_pkg.sv
// Shared constants, opcode enumeration and carrier structs for the AND/bit-clear execution block
package aab_pkg;

  // Widths
  localparam int OPC_W     = 12;
  localparam int DATA_W    = 8;
  localparam int FILE_AW   = 5;
  localparam int BIT_SEL_W = 3;

  // Opcode field positions
  localparam int DEST_POS    = 5;
  localparam int FILE_LSB    = 0;
  localparam int LIT_LSB     = 0;
  localparam int BIT_SEL_LSB = 5;
  localparam int GROUP6_LSB  = 6;
  localparam int GROUP4_LSB  = 8;

  // Opcode match patterns
  localparam logic [5:0] AND_FILE_PATTERN = 6'h05;
  localparam logic [3:0] AND_LIT_PATTERN  = 4'hE;
  localparam logic [3:0] CLR_BIT_PATTERN  = 4'h4;

  // Data constants
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] BIT_ONE   = 8'h01;

  // Decoded operation
  typedef enum logic [1:0] {
    AAB_OP_NONE     = 2'b00,
    AAB_OP_AND_FILE = 2'b01,
    AAB_OP_AND_LIT  = 2'b10,
    AAB_OP_CLR_BIT  = 2'b11
  } aab_op_e;

  // Instruction and operands presented by the decoder and register file
  typedef struct packed {
    logic                valid;
    logic [OPC_W-1:0]    opcode;
    logic [DATA_W-1:0]   acc;
    logic [DATA_W-1:0]   file_data;
  } aab_req_s;

  // Write-back toward accumulator, register file and status
  typedef struct packed {
    logic                done;
    logic                acc_we;
    logic [DATA_W-1:0]   acc_data;
    logic                file_we;
    logic [FILE_AW-1:0]  file_addr;
    logic [DATA_W-1:0]   file_data;
    logic                zero_we;
    logic                zero;
  } aab_res_s;

endpackage

// File: aab_decode.sv
// Opcode decoder for the AND/bit-clear execution block
`timescale 1ns/100ps
module aab_decode
  import aab_pkg::*;
(
  // Instruction word
  input  wire logic [OPC_W-1:0]     i_opcode,
  // Decoded fields
  output aab_op_e                   o_op,
  output logic                      o_dest,
  output logic [FILE_AW-1:0]        o_file_addr,
  output logic [BIT_SEL_W-1:0]      o_bit_sel,
  output logic [DATA_W-1:0]         o_literal
);

  always_comb begin
    if (i_opcode[OPC_W-1:GROUP6_LSB] == AND_FILE_PATTERN) begin
      o_op = AAB_OP_AND_FILE;
    end else if (i_opcode[OPC_W-1:GROUP4_LSB] == AND_LIT_PATTERN) begin
      o_op = AAB_OP_AND_LIT;
    end else if (i_opcode[OPC_W-1:GROUP4_LSB] == CLR_BIT_PATTERN) begin
      o_op = AAB_OP_CLR_BIT;
    end else begin
      o_op = AAB_OP_NONE;
    end
  end

  assign o_dest      = i_opcode[DEST_POS];
  assign o_file_addr = i_opcode[FILE_LSB +: FILE_AW];
  assign o_bit_sel   = i_opcode[BIT_SEL_LSB +: BIT_SEL_W];
  assign o_literal   = i_opcode[LIT_LSB +: DATA_W];

endmodule

// File: aab_exec.sv
// Execution stage for the register AND, literal AND and single-bit clear instructions
`timescale 1ns/100ps
module aab_exec
  import aab_pkg::*;
(
  // Clock and reset
  input  wire logic   I_CLK_SYS,
  input  wire logic   I_RESETN,
  // Instruction and operands
  input  aab_req_s    I_REQ,
  // Write-back
  output aab_res_s    O_RES
);

  aab_op_e                dec_op;
  logic                   dec_dest;
  logic [FILE_AW-1:0]     dec_file_addr;
  logic [BIT_SEL_W-1:0]   dec_bit_sel;
  logic [DATA_W-1:0]      dec_literal;
  logic [DATA_W-1:0]      alu_out;
  aab_res_s               res;
  aab_res_s               next_res;

  aab_decode u_decode (
    .i_opcode    (I_REQ.opcode),
    .o_op        (dec_op),
    .o_dest      (dec_dest),
    .o_file_addr (dec_file_addr),
    .o_bit_sel   (dec_bit_sel),
    .o_literal   (dec_literal)
  );

  // Datapath result of the decoded operation
  always_comb begin
    unique case (dec_op)
      AAB_OP_AND_FILE: begin
        alu_out = I_REQ.acc & I_REQ.file_data;
      end
      AAB_OP_AND_LIT: begin
        alu_out = I_REQ.acc & dec_literal;
      end
      AAB_OP_CLR_BIT: begin
        alu_out = I_REQ.file_data & ~(BIT_ONE << dec_bit_sel);
      end
      AAB_OP_NONE: begin
        alu_out = DATA_ZERO;
      end
    endcase
  end

  // Write-back steering, one cycle per instruction
  always_comb begin
    next_res = '0;
    if (I_REQ.valid) begin
      unique case (dec_op)
        AAB_OP_AND_FILE: begin
          next_res.done      = 1'b1;
          next_res.file_addr = dec_file_addr;
          next_res.acc_we    = ~dec_dest;
          next_res.file_we   = dec_dest;
          next_res.acc_data  = alu_out;
          next_res.file_data = alu_out;
          next_res.zero_we   = 1'b1;
          next_res.zero      = (alu_out == DATA_ZERO);
        end
        AAB_OP_AND_LIT: begin
          next_res.done      = 1'b1;
          next_res.acc_we    = 1'b1;
          next_res.acc_data  = alu_out;
          next_res.zero_we   = 1'b1;
          next_res.zero      = (alu_out == DATA_ZERO);
        end
        AAB_OP_CLR_BIT: begin
          next_res.done      = 1'b1;
          next_res.file_we   = 1'b1;
          next_res.file_addr = dec_file_addr;
          next_res.file_data = alu_out;
        end
        AAB_OP_NONE: begin
          next_res = '0;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RESETN) begin
      res <= '0;
    end else begin
      res <= next_res;
    end
  end

  assign O_RES = res;

  // Checks
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_RESETN);

  // Opcode match and fields taken from the raw word, apart from the decoder
  logic                   chk_andf;
  logic                   chk_andl;
  logic                   chk_clr;
  logic                   chk_known;
  logic [BIT_SEL_W-1:0]   chk_bit;
  logic [FILE_AW-1:0]     chk_addr;
  logic [DATA_W-1:0]      chk_lit;

  assign chk_andf  = (I_REQ.opcode[OPC_W-1:GROUP6_LSB] == AND_FILE_PATTERN);
  assign chk_andl  = (I_REQ.opcode[OPC_W-1:GROUP4_LSB] == AND_LIT_PATTERN);
  assign chk_clr   = (I_REQ.opcode[OPC_W-1:GROUP4_LSB] == CLR_BIT_PATTERN);
  assign chk_known = chk_andf || chk_andl || chk_clr;
  assign chk_bit   = I_REQ.opcode[BIT_SEL_LSB +: BIT_SEL_W];
  assign chk_addr  = I_REQ.opcode[FILE_LSB +: FILE_AW];
  assign chk_lit   = I_REQ.opcode[LIT_LSB +: DATA_W];

  sequence s_andf;
    I_REQ.valid && chk_andf;
  endsequence

  sequence s_andl;
    I_REQ.valid && chk_andl;
  endsequence

  sequence s_and_any;
    I_REQ.valid && (chk_andf || chk_andl);
  endsequence

  sequence s_clr;
    I_REQ.valid && chk_clr;
  endsequence

  a_andf_result_value: assert property (
    s_andf |=> ((O_RES.acc_we ? O_RES.acc_data : O_RES.file_data)
                == ($past(I_REQ.acc) & $past(I_REQ.file_data))))
    else $error("register AND result wrong");

  a_andf_both_data: assert property (
    s_andf |=> (O_RES.acc_data == O_RES.file_data))
    else $error("register AND result not on both data fields");

  a_andf_file_addr: assert property (
    s_andf |=> (O_RES.file_addr == $past(chk_addr)))
    else $error("register AND file address wrong");

  a_andf_to_acc: assert property (
    s_andf ##0 !I_REQ.opcode[DEST_POS] |=> (O_RES.acc_we && !O_RES.file_we))
    else $error("register AND with dest 0 not to accumulator");

  a_andf_to_file: assert property (
    s_andf ##0 I_REQ.opcode[DEST_POS] |=> (O_RES.file_we && !O_RES.acc_we))
    else $error("register AND with dest 1 not to file");

  a_andl_value: assert property (
    s_andl |=> (O_RES.acc_data == ($past(I_REQ.acc) & $past(chk_lit))))
    else $error("literal AND result wrong");

  a_andl_dest_acc: assert property (
    s_andl |=> (O_RES.acc_we && !O_RES.file_we))
    else $error("literal AND not to accumulator");

  a_andl_no_file: assert property (
    s_andl |=> ((O_RES.file_addr == '0) && (O_RES.file_data == DATA_ZERO)))
    else $error("literal AND drove file write-back fields");

  a_clr_other_bits: assert property (
    s_clr |=> (O_RES.file_we && !O_RES.acc_we
               && ((O_RES.file_data | (BIT_ONE << $past(chk_bit)))
                   == ($past(I_REQ.file_data) | (BIT_ONE << $past(chk_bit))))))
    else $error("bit clear disturbed other bits");

  a_clr_file_addr: assert property (
    s_clr |=> (O_RES.file_addr == $past(chk_addr)))
    else $error("bit clear file address wrong");

  a_clr_bit_zero: assert property (
    s_clr |=> (O_RES.file_data[$past(chk_bit)] == 1'b0))
    else $error("selected bit not cleared");

  a_and_zero_flag: assert property (
    s_and_any |=> (O_RES.zero_we
      && (O_RES.zero == ((O_RES.acc_we ? O_RES.acc_data : O_RES.file_data) == DATA_ZERO))))
    else $error("zero flag wrong after AND");

  a_andf_zero_value: assert property (
    s_andf |=> (O_RES.zero == (($past(I_REQ.acc) & $past(I_REQ.file_data)) == DATA_ZERO)))
    else $error("register AND zero flag wrong");

  a_andl_zero_value: assert property (
    s_andl |=> (O_RES.zero == (($past(I_REQ.acc) & $past(chk_lit)) == DATA_ZERO)))
    else $error("literal AND zero flag wrong");

  a_clr_no_flag: assert property (
    s_clr |=> !O_RES.zero_we)
    else $error("bit clear touched zero flag");

  a_one_cycle_done: assert property (
    I_REQ.valid |=> (O_RES.done == $past(chk_known)) ##1
                    (O_RES.done == $past(I_REQ.valid && chk_known)))
    else $error("instruction did not complete in one cycle");

  a_unknown_quiet: assert property (
    I_REQ.valid && !chk_known |=> (O_RES == '0))
    else $error("unrecognised opcode produced write-back");

  a_idle_no_write: assert property (
    !I_REQ.valid |=> !(O_RES.done || O_RES.acc_we || O_RES.file_we || O_RES.zero_we))
    else $error("write-back without instruction");

  a_we_needs_done: assert property (
    (O_RES.acc_we || O_RES.file_we || O_RES.zero_we) |-> O_RES.done)
    else $error("write enable without completed instruction");

  a_done_writes: assert property (
    O_RES.done |-> (O_RES.acc_we || O_RES.file_we))
    else $error("completed instruction wrote nothing");

  // Reset must clear write-back even though other checks are off then
  a_reset_quiet: assert property (
    disable iff (1'b0) !I_RESETN |=> (O_RES == '0))
    else $error("write-back not cleared by reset");

endmodule

// File: tb_and_and_bit_clear_exec.sv
// Self-checking testbench for the AND and bit-clear execution block
`timescale 1ns/100ps
module tb_and_and_bit_clear_exec;
  import aab_pkg::*;

  logic        I_CLK_SYS;
  logic        I_RESETN;
  aab_req_s    I_REQ;
  aab_res_s    O_RES;
  aab_res_s    exp_res;
  logic [31:0] lfsr;
  logic [11:0] op;
  int          mismatches;
  int          n_tests;

  aab_exec dut_u (
    .I_CLK_SYS (I_CLK_SYS),
    .I_RESETN  (I_RESETN),
    .I_REQ     (I_REQ),
    .O_RES     (O_RES)
  );

  initial begin
    I_CLK_SYS = 1'b0;
    forever #2 I_CLK_SYS = ~I_CLK_SYS;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction

  // Write-back expected one cycle after issue
  function automatic aab_res_s model(input aab_req_s q, input logic rn);
    aab_res_s   r;
    logic [7:0] v;
    r = '0;
    if (q.valid && rn) begin
      if (q.opcode[11:6] == 6'h05) begin
        v           = q.acc & q.file_data;
        r.done      = 1'b1;
        r.acc_we    = ~q.opcode[5];
        r.file_we   = q.opcode[5];
        r.acc_data  = v;
        r.file_data = v;
        r.file_addr = q.opcode[4:0];
        r.zero_we   = 1'b1;
        r.zero      = (v == 8'h00);
      end else if (q.opcode[11:8] == 4'hE) begin
        v          = q.acc & q.opcode[7:0];
        r.done     = 1'b1;
        r.acc_we   = 1'b1;
        r.acc_data = v;
        r.zero_we  = 1'b1;
        r.zero     = (v == 8'h00);
      end else if (q.opcode[11:8] == 4'h4) begin
        r.done      = 1'b1;
        r.file_we   = 1'b1;
        r.file_addr = q.opcode[4:0];
        r.file_data = q.file_data & ~(8'h01 << q.opcode[7:5]);
      end
    end
    return r;
  endfunction

  task automatic check(input aab_res_s seen, input aab_res_s exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Checks the previous result, then presents the next instruction
  task automatic issue(input logic rn, input logic v, input logic [11:0] opc,
                       input logic [7:0] a, input logic [7:0] f);
    @(negedge I_CLK_SYS);
    check(O_RES, exp_res);
    I_RESETN        = rn;
    I_REQ.valid     = v;
    I_REQ.opcode    = opc;
    I_REQ.acc       = a;
    I_REQ.file_data = f;
    exp_res         = model(I_REQ, rn);
  endtask

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    I_RESETN   = 1'b0;
    I_REQ      = '0;
    exp_res    = '0;
    lfsr       = 32'hECF9415B;
    mismatches = 0;
    n_tests    = 0;
    repeat (12) @(posedge I_CLK_SYS);
    issue(1'b1, 1'b1, 12'h162, 8'h17, 8'hC2);
    issue(1'b1, 1'b1, 12'h142, 8'h17, 8'hC2);
    issue(1'b1, 1'b1, 12'hE5F, 8'hA3, 8'hFF);
    issue(1'b1, 1'b1, 12'hE00, 8'hFF, 8'hFF);
    issue(1'b1, 1'b1, 12'hEFF, 8'h00, 8'hFF);
    issue(1'b1, 1'b1, 12'h4E3, 8'hFF, 8'hC7);
    issue(1'b1, 1'b1, 12'h17F, 8'h0F, 8'hF0);
    issue(1'b1, 1'b1, 12'h15F, 8'hFF, 8'hFF);
    for (int b = 0; b < 8; b++) begin
      issue(1'b1, 1'b1, {4'h4, b[2:0], 5'h1F}, 8'h5A, 8'hFF);
    end
    issue(1'b1, 1'b1, 12'h300, 8'hFF, 8'hFF);
    issue(1'b1, 1'b0, 12'hEFF, 8'hFF, 8'hFF);
    issue(1'b0, 1'b1, 12'hEFF, 8'hFF, 8'hFF);
    issue(1'b1, 1'b1, 12'h160, 8'h3C, 8'h0F);
    for (int i = 0; i < 400; i++) begin
      lfsr = lfsr_next(lfsr);
      case (lfsr[1:0])
        2'h0:    op = {6'h05, lfsr[7:2]};
        2'h1:    op = {4'hE, lfsr[9:2]};
        2'h2:    op = {4'h4, lfsr[9:2]};
        default: op = lfsr[13:2];
      endcase
      issue(1'b1, lfsr[14] | lfsr[15], op, lfsr[23:16], lfsr[31:24]);
    end
    issue(1'b1, 1'b0, 12'h000, 8'h00, 8'h00);
    @(negedge I_CLK_SYS);
    check(O_RES, exp_res);
    report_and_stop;
  end
endmodule
